// *** rtl/fuse_store_defines.svh ***
/*
  Constants of the configuration fuse store: fuse polarity, field positions,
  factory values, signature addresses and page geometry.
  Assumes inclusion by bare name from the design files only.
*/
`ifndef FUSE_STORE_DEFINES_SVH
`define FUSE_STORE_DEFINES_SVH

// Fuse values: 0 = programmed, 1 = unprogrammed
`define FUSE_PROGRAMMED 1'h0
`define FUSE_UNPROGRAMMED 1'h1

// Factory values of the three fuse bytes
`define EXT_DEFAULT_SMALL 8'hff
`define EXT_DEFAULT_BOOT 8'hf9
`define HIGH_DEFAULT 8'hdf
`define LOW_DEFAULT 8'h62

// Extended byte fields
`define EXT_SELF_WRITE_BIT 0
`define EXT_VECTOR_BIT 0
`define EXT_BOOT_SIZE_LO 1
`define EXT_BOOT_SIZE_HI 2
`define EXT_KEEP_SMALL 8'hfe
`define EXT_KEEP_BOOT 8'hf8

// High byte fields
`define HIGH_RESET_DIS_BIT 7
`define HIGH_DEBUG_BIT 6
`define HIGH_SERIAL_EN_BIT 5
`define HIGH_WDT_BIT 4
`define HIGH_EE_KEEP_BIT 3
`define HIGH_BROWNOUT_HI 2

// Low byte fields
`define LOW_DIV8_BIT 7
`define LOW_CLKOUT_BIT 6
`define LOW_STARTUP_HI 5
`define LOW_STARTUP_LO 4
`define LOW_CLKSRC_HI 3

// Signature address space
`define SIG_ADDR_0 2'h0
`define SIG_ADDR_1 2'h1
`define SIG_ADDR_2 2'h2

// Page geometry
`define FLASH_MSB_BASE 10
`define FLASH_WORD_BITS_SMALL 5
`define FLASH_WORD_BITS_LARGE 6
`define EE_BYTE_BITS 2
`define EE_MSB_SMALL 7
`define EE_MSB_LARGE 8

`endif

// *** rtl/fuse_store_pkg.sv ***
/*
  Types of the configuration fuse store: byte select, working
  configuration carrier and the module state.
  Assumes fuse_store_defines.svh holds the numbers.
*/
package fuse_store_pkg;

  typedef enum logic [1:0] {
    SEL_LOW,
    SEL_HIGH,
    SEL_EXT
  } fuse_sel_t;

  // Raw fuse polarity: 0 means programmed
  typedef struct packed {
    logic [1:0] boot_area_size;
    logic reset_vector_select_fuse;
    logic self_write_enable_fuse;
    logic reset_pin_disable_fuse;
    logic onchip_debug_fuse;
    logic serial_prog_enable_fuse;
    logic watchdog_forced_on;
    logic [2:0] brownout_threshold;
    logic clock_div_by_eight_fuse;
    logic clock_to_pin_fuse;
    logic [1:0] startup_sel;
    logic [3:0] clock_source;
  } work_cfg_t;

  typedef struct packed {
    logic [5:0] page_word_index;
    logic [6:0] page_number_index;
    logic [1:0] ee_byte_index;
    logic [6:0] ee_page_index;
  } geometry_t;

  typedef struct packed {
    logic [7:0] fuse_low;
    logic [7:0] fuse_high;
    logic [7:0] fuse_ext;
    work_cfg_t cfg;
    logic eeprom_keep;
    logic [7:0] rc_trim_register;
    logic prog_seen;
    logic powered;
    logic [7:0] rd_data;
    logic rd_valid;
    logic wr_done;
    logic wr_refused;
    logic erase_eeprom;
    logic clk_pin_sel;
    geometry_t geo;
  } store_state_t;

endpackage

// *** rtl/fuse_signature_config_store.sv ***
/*
  Configuration fuse store with identification signature, oscillator trim
  copy and flash/EEPROM page address split.
  Assumes the programmer drives requests synchronous to clk_sys_in, one per
  cycle, and that reset_in marks power-up of the part.
*/
`timescale 1ns/1ns
`include "fuse_store_defines.svh"

module fuse_signature_config_store #(
  parameter int VARIANT = 0,
  parameter logic [7:0] CAL_VALUE = 8'h80,
  // Identity bytes: arbitrary values, not those of any real part
  parameter logic [7:0] ID_0 = 8'h5a,
  parameter logic [7:0] ID_1 = 8'h01,
  parameter logic [7:0] ID_2 = 8'h02
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_in,
  // Programming session
  input wire logic prog_mode_in,
  input wire logic lock_bit_one_in,
  input wire logic chip_erase_in,
  // Fuse write
  input wire logic wr_en_in,
  input wire logic wr_serial_in,
  input wire fuse_store_pkg::fuse_sel_t wr_sel_in,
  input wire logic [7:0] wr_data_in,
  // Read
  input wire logic rd_en_in,
  input wire logic rd_signature_in,
  input wire logic rd_high_in,
  input wire logic [1:0] rd_addr_in,
  // Address split
  input wire logic [12:0] flash_word_addr_in,
  input wire logic [8:0] eeprom_byte_address_in,
  // Read, write and erase answers
  output logic [7:0] rd_data_out,
  output logic rd_valid_out,
  output logic wr_done_out,
  output logic wr_refused_out,
  output logic erase_eeprom_out,
  // Working configuration and page address split
  output fuse_store_pkg::work_cfg_t cfg_out,
  output logic eeprom_keep_out,
  output logic [7:0] rc_trim_register_out,
  output logic port_b_bit_zero_pin_sel_out,
  output fuse_store_pkg::geometry_t geo_out
);
  import fuse_store_pkg::*;

  localparam logic [7:0] EXT_DEFAULT = (VARIANT == 0) ? `EXT_DEFAULT_SMALL : `EXT_DEFAULT_BOOT;
  localparam logic [7:0] EXT_KEEP = (VARIANT == 0) ? `EXT_KEEP_SMALL : `EXT_KEEP_BOOT;
  localparam int FLASH_WBITS = (VARIANT == 2) ? `FLASH_WORD_BITS_LARGE : `FLASH_WORD_BITS_SMALL;
  localparam int FLASH_MSB = `FLASH_MSB_BASE + VARIANT;
  localparam int EE_MSB = (VARIANT == 0) ? `EE_MSB_SMALL : `EE_MSB_LARGE;

  store_state_t st_q;
  store_state_t st_d;

  // Bits lo..msb of an address, shifted down
  function automatic logic [12:0] addr_field(input logic [12:0] addr, input int lo,
                                             input int msb);
    logic [12:0] mask;
    mask = 13'(({13'h0, 1'h1} << (msb - lo + 1)) - 14'h1);
    return 13'(addr >> lo) & mask;
  endfunction

  function automatic work_cfg_t decode_cfg(input logic [7:0] lo, input logic [7:0] hi,
                                           input logic [7:0] ext);
    work_cfg_t c;
    c.boot_area_size = ext[`EXT_BOOT_SIZE_HI:`EXT_BOOT_SIZE_LO];
    c.reset_vector_select_fuse = (VARIANT == 0) ? 1'h1 : ext[`EXT_VECTOR_BIT];
    c.self_write_enable_fuse = (VARIANT == 0) ? ext[`EXT_SELF_WRITE_BIT] : 1'h1;
    c.reset_pin_disable_fuse = hi[`HIGH_RESET_DIS_BIT];
    c.onchip_debug_fuse = hi[`HIGH_DEBUG_BIT];
    c.serial_prog_enable_fuse = hi[`HIGH_SERIAL_EN_BIT];
    c.watchdog_forced_on = hi[`HIGH_WDT_BIT];
    c.brownout_threshold = hi[`HIGH_BROWNOUT_HI:0];
    c.clock_div_by_eight_fuse = lo[`LOW_DIV8_BIT];
    c.clock_to_pin_fuse = lo[`LOW_CLKOUT_BIT];
    c.startup_sel = lo[`LOW_STARTUP_HI:`LOW_STARTUP_LO];
    c.clock_source = lo[`LOW_CLKSRC_HI:0];
    return c;
  endfunction

  always_comb begin
    logic capture;
    logic [7:0] wval;
    capture = 1'h0;
    wval = 8'h0;
    st_d = st_q;
    st_d.rd_valid = 1'h0;
    st_d.wr_done = 1'h0;
    st_d.wr_refused = 1'h0;
    st_d.erase_eeprom = 1'h0;
    if (reset_in) begin
      // Fresh part: factory fuses, then the trim copy that every reset performs
      st_d.fuse_low = `LOW_DEFAULT;
      st_d.fuse_high = `HIGH_DEFAULT;
      st_d.fuse_ext = EXT_DEFAULT;
      st_d.cfg = decode_cfg(`LOW_DEFAULT, `HIGH_DEFAULT, EXT_DEFAULT);
      st_d.eeprom_keep = 1'(`HIGH_DEFAULT >> `HIGH_EE_KEEP_BIT);
      st_d.rc_trim_register = CAL_VALUE;
      st_d.prog_seen = 1'h0;
      st_d.powered = 1'h0;
      st_d.rd_data = 8'h0;
      st_d.clk_pin_sel = 1'h0;
      st_d.geo = '0;
    end else begin
      st_d.powered = 1'h1;
      st_d.prog_seen = prog_mode_in;
      // Latch on power-up in normal mode, on session entry and on session exit
      if (!st_q.powered && !prog_mode_in) begin
        capture = 1'h1;
      end
      if (prog_mode_in != st_q.prog_seen) begin
        capture = 1'h1;
      end
      if (capture) begin
        st_d.cfg = decode_cfg(st_q.fuse_low, st_q.fuse_high, st_q.fuse_ext);
      end
      // Keep fuse is not latched: it tracks the store directly
      st_d.eeprom_keep = st_q.fuse_high[`HIGH_EE_KEEP_BIT];
      st_d.clk_pin_sel = (st_q.cfg.clock_to_pin_fuse == `FUSE_PROGRAMMED);
      if (wr_en_in && prog_mode_in) begin
        if (lock_bit_one_in == `FUSE_PROGRAMMED) begin
          st_d.wr_refused = 1'h1;
        end else begin
          st_d.wr_done = 1'h1;
          case (wr_sel_in)
            SEL_LOW: begin
              st_d.fuse_low = wr_data_in;
            end
            SEL_HIGH: begin
              wval = wr_data_in;
              if (wr_serial_in) begin
                wval[`HIGH_SERIAL_EN_BIT] = st_q.fuse_high[`HIGH_SERIAL_EN_BIT];
              end
              st_d.fuse_high = wval;
            end
            SEL_EXT: begin
              st_d.fuse_ext = wr_data_in | EXT_KEEP;
            end
            default: begin
              st_d.wr_done = 1'h0;
              st_d.wr_refused = 1'h1;
            end
          endcase
        end
      end
      // Erase never touches the fuse store; EEPROM survives when keep is programmed
      if (chip_erase_in && prog_mode_in) begin
        st_d.erase_eeprom = (st_q.fuse_high[`HIGH_EE_KEEP_BIT] != `FUSE_PROGRAMMED);
      end
      if (rd_en_in) begin
        st_d.rd_valid = 1'h1;
        if (rd_signature_in) begin
          // Signature answers regardless of lock state
          case (rd_addr_in)
            `SIG_ADDR_0: st_d.rd_data = rd_high_in ? CAL_VALUE : ID_0;
            `SIG_ADDR_1: st_d.rd_data = ID_1;
            `SIG_ADDR_2: st_d.rd_data = ID_2;
            default: st_d.rd_data = 8'hff;
          endcase
        end else begin
          case (rd_addr_in)
            2'h0: st_d.rd_data = st_q.fuse_low;
            2'h1: st_d.rd_data = st_q.fuse_high;
            2'h2: st_d.rd_data = st_q.fuse_ext;
            default: st_d.rd_data = 8'hff;
          endcase
        end
      end
      st_d.geo.page_word_index = 6'(addr_field(flash_word_addr_in, 0, FLASH_WBITS - 1));
      st_d.geo.page_number_index =
        7'(addr_field(flash_word_addr_in, FLASH_WBITS, FLASH_MSB));
      st_d.geo.ee_byte_index =
        2'(addr_field({4'h0, eeprom_byte_address_in}, 0, `EE_BYTE_BITS - 1));
      st_d.geo.ee_page_index =
        7'(addr_field({4'h0, eeprom_byte_address_in}, `EE_BYTE_BITS, EE_MSB));
    end
  end

  always_ff @(posedge clk_sys_in) begin
    st_q <= st_d;
  end

  assign rd_data_out = st_q.rd_data;
  assign rd_valid_out = st_q.rd_valid;
  assign wr_done_out = st_q.wr_done;
  assign wr_refused_out = st_q.wr_refused;
  assign erase_eeprom_out = st_q.erase_eeprom;
  assign cfg_out = st_q.cfg;
  assign eeprom_keep_out = st_q.eeprom_keep;
  assign rc_trim_register_out = st_q.rc_trim_register;
  assign port_b_bit_zero_pin_sel_out = st_q.clk_pin_sel;
  assign geo_out = st_q.geo;

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (reset_in);

  AST_LOCK_REFUSES: assert property (
    wr_en_in && prog_mode_in && !lock_bit_one_in
      |=> wr_refused_out && !wr_done_out && $stable({st_q.fuse_low, st_q.fuse_high,
                                                      st_q.fuse_ext}))
    else $error("Fuse write accepted while lock bit one programmed");

  AST_SERIAL_KEEPS_ENABLE: assert property (
    wr_en_in && prog_mode_in && lock_bit_one_in && wr_serial_in && wr_sel_in == SEL_HIGH
      |=> $stable(st_q.fuse_high[`HIGH_SERIAL_EN_BIT]))
    else $error("Serial write changed the serial programming enable fuse");

  AST_ERASE_KEEPS_FUSES: assert property (
    chip_erase_in && !wr_en_in
      |=> $stable({st_q.fuse_low, st_q.fuse_high, st_q.fuse_ext}))
    else $error("Chip erase changed a fuse");

  AST_SESSION_HOLDS_CFG: assert property (
    prog_mode_in && st_q.prog_seen && st_q.powered |=> $stable(cfg_out))
    else $error("Working configuration moved inside a programming session");

  AST_ENTRY_LATCHES: assert property (
    prog_mode_in && !st_q.prog_seen && st_q.powered
      |=> cfg_out == decode_cfg($past(st_q.fuse_low), $past(st_q.fuse_high),
                                $past(st_q.fuse_ext)))
    else $error("Session entry did not latch the fuses");

  AST_KEEP_IMMEDIATE: assert property (
    wr_en_in && prog_mode_in && lock_bit_one_in && wr_sel_in == SEL_HIGH
      |=> ##1 eeprom_keep_out == $past(wr_data_in[`HIGH_EE_KEEP_BIT], 2))
    else $error("EEPROM keep fuse did not act at once");

  AST_TRIM_AFTER_RESET: assert property (
    $past(reset_in) |-> rc_trim_register_out == CAL_VALUE)
    else $error("Trim register not loaded from calibration byte");

  AST_SIG_READ: assert property (
    rd_en_in && rd_signature_in && rd_addr_in == `SIG_ADDR_1
      |=> rd_valid_out && rd_data_out == ID_1)
    else $error("Signature byte one read wrong");

  AST_EXT_UPPER_ONES: assert property (
    (st_q.fuse_ext & EXT_KEEP) == EXT_KEEP)
    else $error("Unused extended fuse bits not reading one");

  AST_CLKPIN_FOLLOWS: assert property (
    port_b_bit_zero_pin_sel_out == !$past(cfg_out.clock_to_pin_fuse))
    else $error("Clock pin select does not follow the clock output fuse");

  AST_LOW_WRITE: assert property (
    wr_en_in && prog_mode_in && lock_bit_one_in && wr_sel_in == SEL_LOW
      |=> wr_done_out && st_q.fuse_low == $past(wr_data_in))
    else $error("Accepted low fuse write not stored");

  AST_HIGH_PARALLEL: assert property (
    wr_en_in && prog_mode_in && lock_bit_one_in && !wr_serial_in && wr_sel_in == SEL_HIGH
      |=> st_q.fuse_high == $past(wr_data_in))
    else $error("Parallel high fuse write not stored whole");

  AST_EXT_WRITE: assert property (
    wr_en_in && prog_mode_in && lock_bit_one_in && wr_sel_in == SEL_EXT
      |=> st_q.fuse_ext == ($past(wr_data_in) | EXT_KEEP))
    else $error("Extended fuse write stored wrongly");

  AST_WRITE_IDLE: assert property (
    !(wr_en_in && prog_mode_in) |=> !wr_done_out && !wr_refused_out)
    else $error("Write answer without a write request");

  AST_ERASE_FLAG: assert property (
    chip_erase_in && prog_mode_in
      |=> erase_eeprom_out == $past(st_q.fuse_high[`HIGH_EE_KEEP_BIT]))
    else $error("EEPROM erase flag disagrees with the keep fuse");

  AST_ERASE_IDLE: assert property (
    !(chip_erase_in && prog_mode_in) |=> !erase_eeprom_out)
    else $error("EEPROM erase flag without an erase command");

  AST_READ_VALID: assert property (
    rd_en_in |=> rd_valid_out)
    else $error("Read request not answered");

  AST_READ_IDLE: assert property (
    !rd_en_in |=> !rd_valid_out)
    else $error("Read answer without a read request");

  AST_CAL_READ: assert property (
    rd_en_in && rd_signature_in && rd_high_in && rd_addr_in == `SIG_ADDR_0
      |=> rd_data_out == CAL_VALUE)
    else $error("Calibration byte read wrong");

  AST_FUSE_READ_HIGH: assert property (
    rd_en_in && !rd_signature_in && rd_addr_in == 2'h1
      |=> rd_data_out == $past(st_q.fuse_high))
    else $error("High fuse byte read wrong");

  AST_POWERUP_LATCH: assert property (
    !st_q.powered && !prog_mode_in
      |=> cfg_out == decode_cfg($past(st_q.fuse_low), $past(st_q.fuse_high),
                                $past(st_q.fuse_ext)))
    else $error("Power-up did not latch the fuses");

  AST_EXIT_LATCHES: assert property (
    !prog_mode_in && st_q.prog_seen
      |=> cfg_out == decode_cfg($past(st_q.fuse_low), $past(st_q.fuse_high),
                                $past(st_q.fuse_ext)))
    else $error("Session exit did not latch the fuses");

  AST_NORMAL_HOLDS: assert property (
    !prog_mode_in && !st_q.prog_seen && st_q.powered |=> $stable(cfg_out))
    else $error("Working configuration moved outside a latch event");

  AST_FLASH_WORD_SPLIT: assert property (
    st_q.powered |-> geo_out.page_word_index[4:0] == $past(flash_word_addr_in[4:0]))
    else $error("Flash word index not taken from the low address bits");

  AST_EE_BYTE_SPLIT: assert property (
    st_q.powered |-> geo_out.ee_byte_index == $past(eeprom_byte_address_in[1:0]))
    else $error("EEPROM byte index not taken from the low address bits");

endmodule

// *** test/fuse_programmer_model.sv ***
/*
  Behavioural programmer on the far side of the fuse store: session, lock,
  chip erase, fuse write and read requests, one at a time.
  Assumes the bench calls its tasks and answers arrive one cycle after the take.
*/
`timescale 1ns/1ns
module fuse_programmer_model (
  // Clock and answers
  input wire logic clk_sys_in,
  input wire logic [7:0] rd_data_in,
  input wire logic rd_valid_in,
  input wire logic wr_done_in,
  input wire logic wr_refused_in,
  input wire logic erase_eeprom_in,
  // Session
  output logic prog_mode_out,
  output logic lock_bit_one_out,
  output logic chip_erase_out,
  // Requests
  output logic wr_en_out,
  output logic wr_serial_out,
  output fuse_store_pkg::fuse_sel_t wr_sel_out,
  output logic [7:0] wr_data_out,
  output logic rd_en_out,
  output logic rd_signature_out,
  output logic rd_high_out,
  output logic [1:0] rd_addr_out
);
  import fuse_store_pkg::*;

  initial begin
    prog_mode_out = 1'b0;
    lock_bit_one_out = 1'b1;
    chip_erase_out = 1'b0;
    wr_en_out = 1'b0;
    wr_serial_out = 1'b0;
    wr_sel_out = SEL_LOW;
    wr_data_out = 8'h00;
    rd_en_out = 1'b0;
    rd_signature_out = 1'b0;
    rd_high_out = 1'b0;
    rd_addr_out = 2'h0;
  end

  // Lock is only set by the bench after its accepted fuse writes are done
  task automatic set_mode(input logic prog, input logic lock_n);
    @(posedge clk_sys_in);
    #1;
    prog_mode_out = prog;
    lock_bit_one_out = lock_n;
  endtask

  task automatic write_byte(input logic serial, input fuse_sel_t sel, input logic [7:0] data,
      output logic done, output logic refused);
    @(posedge clk_sys_in);
    #1;
    wr_en_out = 1'b1;
    wr_serial_out = serial;
    wr_sel_out = sel;
    wr_data_out = data;
    @(posedge clk_sys_in);
    #1;
    done = wr_done_in;
    refused = wr_refused_in;
    wr_en_out = 1'b0;
    // Released data lines must not keep showing the last byte
    wr_data_out = ~data;
  endtask

  task automatic read_byte(input logic sig, input logic high, input logic [1:0] addr,
      output logic [7:0] data, output logic valid);
    @(posedge clk_sys_in);
    #1;
    rd_en_out = 1'b1;
    rd_signature_out = sig;
    rd_high_out = high;
    rd_addr_out = addr;
    @(posedge clk_sys_in);
    #1;
    data = rd_data_in;
    valid = rd_valid_in;
    rd_en_out = 1'b0;
    rd_addr_out = ~addr;
  endtask

  task automatic erase(output logic flag);
    @(posedge clk_sys_in);
    #1;
    chip_erase_out = 1'b1;
    @(posedge clk_sys_in);
    #1;
    flag = erase_eeprom_in;
    chip_erase_out = 1'b0;
  endtask
endmodule

// *** test/fuse_signature_config_store_tb.sv ***
/*
  Self-checking bench of the fuse store: read table, session latching,
  serial guard, erase, lock refusal and a second reset.
  Assumes the programmer model drives every request pin.
*/
`timescale 1ns/1ns
module fuse_signature_config_store_tb;
  import fuse_store_pkg::*;

  logic clk_sys_in = 1'b0;
  logic reset_in = 1'b1;
  logic prog_mode, lock_n, erase_cmd, wr_en, wr_serial, rd_en, rd_sig, rd_high;
  fuse_sel_t wr_sel;
  logic [7:0] wr_data, rd_data, trim;
  logic [1:0] rd_addr;
  logic rd_valid, wr_done, wr_refused, erase_ee, ee_keep, pin_sel, e;
  logic [12:0] flash_addr = 13'h1abc;
  logic [8:0] ee_addr = 9'h1e7;
  work_cfg_t cfg;
  geometry_t geo;
  int fail_count = 0;
  int total_checks = 0;
  // Rows: signature, high byte, address, expected byte
  localparam logic [11:0] ROWS [9] = '{12'h062, 12'h1df, 12'h2f9, 12'h3ff, 12'h811,
    12'h922, 12'ha33, 12'hbff, 12'hc3c};

  always #50 clk_sys_in = ~clk_sys_in;

  // Identity bytes are arbitrary values
  fuse_signature_config_store #(.VARIANT(2), .CAL_VALUE(8'h3c), .ID_0(8'h11), .ID_1(8'h22),
      .ID_2(8'h33)) dut (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
    .prog_mode_in(prog_mode), .lock_bit_one_in(lock_n), .chip_erase_in(erase_cmd),
    .wr_en_in(wr_en), .wr_serial_in(wr_serial), .wr_sel_in(wr_sel), .wr_data_in(wr_data),
    .rd_en_in(rd_en), .rd_signature_in(rd_sig), .rd_high_in(rd_high), .rd_addr_in(rd_addr),
    .flash_word_addr_in(flash_addr), .eeprom_byte_address_in(ee_addr),
    .rd_data_out(rd_data), .rd_valid_out(rd_valid), .wr_done_out(wr_done),
    .wr_refused_out(wr_refused), .erase_eeprom_out(erase_ee), .cfg_out(cfg),
    .eeprom_keep_out(ee_keep), .rc_trim_register_out(trim),
    .port_b_bit_zero_pin_sel_out(pin_sel), .geo_out(geo));

  fuse_programmer_model prog (.clk_sys_in(clk_sys_in), .rd_data_in(rd_data),
    .rd_valid_in(rd_valid), .wr_done_in(wr_done), .wr_refused_in(wr_refused),
    .erase_eeprom_in(erase_ee), .prog_mode_out(prog_mode), .lock_bit_one_out(lock_n),
    .chip_erase_out(erase_cmd), .wr_en_out(wr_en), .wr_serial_out(wr_serial),
    .wr_sel_out(wr_sel), .wr_data_out(wr_data), .rd_en_out(rd_en),
    .rd_signature_out(rd_sig), .rd_high_out(rd_high), .rd_addr_out(rd_addr));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rdchk(input logic sig, input logic high, input logic [1:0] a,
      input logic [7:0] exp);
    logic [7:0] d;
    logic v;
    prog.read_byte(sig, high, a, d, v);
    check({15'h0, v}, 16'h1);
    check({8'h0, d}, {8'h0, exp});
  endtask

  task automatic wr(input logic ser, input fuse_sel_t sel, input logic [7:0] d,
      input logic [1:0] exp);
    logic dn, rf;
    prog.write_byte(ser, sel, d, dn, rf);
    check({14'h0, dn, rf}, {14'h0, exp});
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    #500000;
    fail_count++;
    wrap_up();
  end

  initial begin
    repeat (16) @(posedge clk_sys_in);
    #1;
    reset_in = 1'b0;
    repeat (3) @(posedge clk_sys_in);
    #1;
    foreach (ROWS[i]) begin
      rdchk(ROWS[i][11], ROWS[i][10], ROWS[i][9:8], ROWS[i][7:0]);
    end
    check({cfg.clock_div_by_eight_fuse, cfg.clock_to_pin_fuse, cfg.startup_sel,
      cfg.clock_source}, 16'h62);
    check({cfg.reset_pin_disable_fuse, cfg.onchip_debug_fuse, cfg.serial_prog_enable_fuse,
      cfg.watchdog_forced_on, ee_keep, cfg.brownout_threshold}, 16'hdf);
    check({cfg.boot_area_size, cfg.reset_vector_select_fuse}, 16'h1);
    check({15'h0, cfg.self_write_enable_fuse}, 16'h1);
    check({8'h0, trim}, 16'h3c);
    check({geo.page_word_index, geo.page_number_index}, {6'h3c, 7'h6a});
    check({geo.ee_byte_index, geo.ee_page_index}, {2'h3, 7'h79});
    prog.set_mode(1'b1, 1'b1);
    repeat (3) @(posedge clk_sys_in);
    wr(1'b0, SEL_LOW, 8'h22, 2'h2);
    rdchk(1'b0, 1'b0, 2'h0, 8'h22);
    check({15'h0, cfg.clock_to_pin_fuse}, 16'h1);
    wr(1'b0, SEL_HIGH, 8'hd7, 2'h2);
    @(posedge clk_sys_in);
    #1;
    check({15'h0, ee_keep}, 16'h0);
    prog.erase(e);
    check({15'h0, e}, 16'h0);
    // Serial path may not touch the serial-enable bit
    wr(1'b1, SEL_HIGH, 8'hff, 2'h2);
    rdchk(1'b0, 1'b0, 2'h1, 8'hdf);
    prog.erase(e);
    check({15'h0, e}, 16'h1);
    rdchk(1'b0, 1'b0, 2'h0, 8'h22);
    wr(1'b0, SEL_EXT, 8'h02, 2'h2);
    rdchk(1'b0, 1'b0, 2'h2, 8'hfa);
    prog.set_mode(1'b1, 1'b0);
    wr(1'b0, SEL_LOW, 8'h00, 2'h1);
    rdchk(1'b0, 1'b0, 2'h0, 8'h22);
    rdchk(1'b1, 1'b0, 2'h0, 8'h11);
    check({15'h0, cfg.clock_to_pin_fuse}, 16'h1);
    prog.set_mode(1'b0, 1'b1);
    repeat (4) @(posedge clk_sys_in);
    #1;
    check({15'h0, cfg.clock_to_pin_fuse}, 16'h0);
    check({15'h0, pin_sel}, 16'h1);
    check({cfg.boot_area_size, cfg.reset_vector_select_fuse}, 16'h2);
    flash_addr = 13'h0123;
    ee_addr = 9'h0d6;
    reset_in = 1'b1;
    repeat (2) @(posedge clk_sys_in);
    #1;
    reset_in = 1'b0;
    repeat (3) @(posedge clk_sys_in);
    #1;
    check({8'h0, trim}, 16'h3c);
    check({15'h0, cfg.clock_to_pin_fuse}, 16'h1);
    rdchk(1'b0, 1'b0, 2'h0, 8'h62);
    check({geo.page_word_index, geo.page_number_index}, {6'h23, 7'h04});
    check({geo.ee_byte_index, geo.ee_page_index}, {2'h2, 7'h35});
    wrap_up();
  end
endmodule
